// [hw/cmpes_pkg.sv]
// constants and types shared by the compressor enable and status block
package cmpes_pkg;
    // clock rate
    localparam int unsigned CLK_HZ = 10_000_000;
    // timing figures in milliseconds and the derived cycle counts
    localparam int unsigned RETRY_MS       = 5000;
    localparam int unsigned RETRY_CYC      = RETRY_MS * (CLK_HZ / 1000);
    localparam int unsigned CTRL_TMO_MS    = 100;
    localparam int unsigned CTRL_TMO_CYC   = CTRL_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned CAN_TMO_MS     = 100;
    localparam int unsigned CAN_TMO_CYC    = CAN_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned SLOW_HALF_MS   = 500;
    localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned FAST_HALF_MS   = 50;
    localparam int unsigned FAST_HALF_CYC  = FAST_HALF_MS * (CLK_HZ / 1000);
    // device id
    localparam int unsigned ID_W           = 6;
    localparam logic [5:0]  ID_RST         = 6'h00;
    // number of solenoid channels
    localparam int unsigned SOL_N          = 8;
    // register map, byte addresses
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_FAULT      = 4'h8;
    localparam logic [3:0]  REG_DEVID      = 4'hC;
    // control register fields
    localparam int unsigned CTRL_CLR_STICKY = 0;
    localparam int unsigned CTRL_NVM_LOAD   = 1;
    // status register fields
    localparam int unsigned ST_DRIVE       = 0;
    localparam int unsigned ST_ENABLED     = 1;
    localparam int unsigned ST_CAN_OK      = 2;
    localparam int unsigned ST_CLOSED_LOOP = 3;
    localparam int unsigned ST_FULL        = 4;
    localparam int unsigned ST_LOCKOUT     = 5;
    // fault register fields
    localparam int unsigned FL_SHORT_NOW    = 0;
    localparam int unsigned FL_SHORT_STICKY = 1;
    localparam int unsigned FL_SOL_NOW      = 8;
    localparam int unsigned FL_SOL_STICKY   = 16;
    // indicator colours
    typedef enum logic [1:0] {
        CMPES_OFF    = 2'h0,
        CMPES_GREEN  = 2'h1,
        CMPES_RED    = 2'h2,
        CMPES_ORANGE = 2'h3
    } cmpes_color_t;
    // indicator modes, one-hot
    typedef enum logic [5:0] {
        CMPES_M_NOCAN   = 6'h01,
        CMPES_M_COMPF   = 6'h02,
        CMPES_M_SOLF    = 6'h04,
        CMPES_M_STICKY  = 6'h08,
        CMPES_M_IDLE    = 6'h10,
        CMPES_M_RUN     = 6'h20
    } cmpes_mode_t;
endpackage : cmpes_pkg

// [hw/cmpes_timer.sv]
// down counter that reports expiry of a reloadable interval
`timescale 1ns/1ns
`default_nettype none
module cmpes_timer #(
    parameter int unsigned CYCLES = 16
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic reload,
    output var  logic expired
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    logic [W-1:0] cnt_q;

    // counter starts expired so nothing waits after reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (reload) begin
                cnt_q <= LOAD;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    always_comb begin
        expired = (cnt_q == '0);
    end
endmodule : cmpes_timer
`default_nettype wire

// [hw/cmpes_top.sv]
// compressor enable, indicator and fault logic with an avalon-mm slave
//
// Contract
// - drive only if enabled, declared, can ok, id
// - act only on control with own id
// - red strobe when can unhealthy
// - slow green when healthy and disabled
// - slow orange when sticky fault and disabled
// - green strobe once enabled
// - pneumatics control enables closed loop
// - pressure full or absent keeps output off
// - device id defaults to zero
// - no id conflict check with others
// - compressor indicator equals compressor drive
// - closed loop disabled keeps output off
// - short fault: current and sticky flags
// - clear command clears sticky flags
// - sticky survives power, clears by command
// - retry after overcurrent every five seconds
// - red blinks solenoid index plus one, lowest
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module cmpes_top #(
    parameter int unsigned RETRY_CYC     = cmpes_pkg::RETRY_CYC,
    parameter int unsigned CTRL_TMO_CYC  = cmpes_pkg::CTRL_TMO_CYC,
    parameter int unsigned CAN_TMO_CYC   = cmpes_pkg::CAN_TMO_CYC,
    parameter int unsigned SLOW_HALF_CYC = cmpes_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYC = cmpes_pkg::FAST_HALF_CYC
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // decoded control frame from the can receiver
    input  wire logic                       ctrl_valid,
    input  wire logic [cmpes_pkg::ID_W-1:0] ctrl_id,
    input  wire logic                       ctrl_robot_en,
    input  wire logic                       ctrl_pneu_used,
    input  wire logic                       ctrl_closed_loop,
    input  wire logic                       ctrl_clr_sticky,
    input  wire logic                       can_frame_ok,
    input  wire logic                       can_bus_err,
    // field inputs
    input  wire logic                       press_not_full,
    input  wire logic                       comp_short,
    input  wire logic [cmpes_pkg::SOL_N-1:0] sol_fault,
    // sticky flags held in non-volatile storage
    input  wire logic [cmpes_pkg::SOL_N:0]  nvm_sticky,
    output logic      [cmpes_pkg::SOL_N:0]  nvm_sticky_wr,
    // avalon-mm slave
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    // outputs
    output logic                            comp_drive,
    output logic                            compressor_indicator,
    output cmpes_pkg::cmpes_color_t         status_indicator
);
    localparam int unsigned SN = cmpes_pkg::SOL_N;

    logic                       can_ok_q;
    logic                       robot_en_q;
    logic                       pneu_q;
    logic                       closed_loop_q;
    logic [cmpes_pkg::ID_W-1:0] dev_id_q;
    logic                       short_sticky_q;
    logic [SN-1:0]              sol_sticky_q;
    logic                       drive_d;
    logic                       ack_q;
    logic                       id_hit;
    logic                       sw_clr;
    logic                       nvm_load;
    logic                       can_exp;
    logic                       ctrl_exp;
    logic                       retry_exp;
    logic                       enabled;
    logic                       lockout;
    logic                       sticky_any;
    logic                       slow_tick;
    logic                       fast_tick;
    logic [3:0]                 sol_blinks;
    cmpes_pkg::cmpes_mode_t     mode;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // link health and host control

    // ids of other device types are not compared
    always_comb begin
        id_hit = ctrl_valid && (ctrl_id == dev_id_q);
    end

    cmpes_timer #(.CYCLES(CAN_TMO_CYC)) u_can_tmr (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .reload  (can_frame_ok),
        .expired (can_exp)
    );

    // health from traffic; a bus error wins so drive cannot flicker
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            can_ok_q <= 1'b0;
        end else if (clk_en) begin
            can_ok_q <= !can_bus_err && (can_frame_ok || !can_exp);
        end
    end

    cmpes_timer #(.CYCLES(CTRL_TMO_CYC)) u_ctrl_tmr (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .reload  (id_hit),
        .expired (ctrl_exp)
    );

    // control for any pneumatics function enables
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            robot_en_q <= 1'b0;
            pneu_q     <= 1'b0;
        end else if (clk_en) begin
            if (id_hit) begin
                robot_en_q <= ctrl_robot_en;
                pneu_q     <= ctrl_pneu_used;
            end else if (ctrl_exp) begin
                robot_en_q <= 1'b0;
                pneu_q     <= 1'b0;
            end
        end
    end

    // host may turn closed loop off; default on
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            closed_loop_q <= 1'b1;
        end else if (clk_en && id_hit) begin
            closed_loop_q <= ctrl_closed_loop;
        end
    end

    always_comb begin
        enabled = robot_en_q && pneu_q && can_ok_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // compressor drive

    // retry window restarts on each short while driving
    cmpes_timer #(.CYCLES(RETRY_CYC)) u_retry_tmr (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .reload  (comp_short && comp_drive),
        .expired (retry_exp)
    );

    // no new attempt inside the window
    always_comb begin
        lockout = !retry_exp;
    end

    // closed loop off forces output off
    always_comb begin
        drive_d = enabled && closed_loop_q && press_not_full && !lockout && !comp_short;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comp_drive           <= 1'b0;
            compressor_indicator <= 1'b0;
        end else if (clk_en) begin
            comp_drive           <= drive_d;
            compressor_indicator <= drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // faults

    always_comb begin
        sw_clr   = avs_write && ack_q && (avs_address == cmpes_pkg::REG_CTRL)
                   && avs_writedata[cmpes_pkg::CTRL_CLR_STICKY];
        nvm_load = avs_write && ack_q && (avs_address == cmpes_pkg::REG_CTRL)
                   && avs_writedata[cmpes_pkg::CTRL_NVM_LOAD];
    end

    // sticky short flag; set beats clear
    // reset clears it; restored from storage by an nvm load write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            short_sticky_q <= 1'b0;
            sol_sticky_q   <= '0;
        end else if (clk_en) begin
            if (nvm_load) begin
                short_sticky_q <= nvm_sticky[SN] | comp_short;
                sol_sticky_q   <= nvm_sticky[SN-1:0] | sol_fault;
            end else if ((id_hit && ctrl_clr_sticky) || sw_clr) begin
                short_sticky_q <= comp_short;
                sol_sticky_q   <= sol_fault;
            end else begin
                short_sticky_q <= short_sticky_q | comp_short;
                sol_sticky_q   <= sol_sticky_q | sol_fault;
            end
        end
    end

    // sticky image written back to storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nvm_sticky_wr <= '0;
        end else if (clk_en) begin
            nvm_sticky_wr <= {short_sticky_q, sol_sticky_q};
        end
    end

    always_comb begin
        sticky_any = short_sticky_q || (sol_sticky_q != '0);
    end

    // lowest faulted index, blinks are index plus one
    always_comb begin
        sol_blinks = 4'h0;
        for (int i = SN - 1; i >= 0; i--) begin
            if (sol_fault[i]) begin
                sol_blinks = 4'(i + 1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status indicator

    always_comb begin
        if (!can_ok_q) begin
            mode = cmpes_pkg::CMPES_M_NOCAN;
        end else if (lockout) begin
            mode = cmpes_pkg::CMPES_M_COMPF;
        end else if (sol_blinks != 4'h0) begin
            mode = cmpes_pkg::CMPES_M_SOLF;
        end else if (enabled) begin
            mode = cmpes_pkg::CMPES_M_RUN;
        end else if (sticky_any) begin
            mode = cmpes_pkg::CMPES_M_STICKY;
        end else begin
            mode = cmpes_pkg::CMPES_M_IDLE;
        end
    end

    logic       slow_ph_q;
    logic       fast_ph_q;
    logic [4:0] blink_q;
    logic       slow_exp;
    logic       fast_exp;

    cmpes_timer #(.CYCLES(SLOW_HALF_CYC)) u_slow_tmr (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .reload  (slow_exp),
        .expired (slow_exp)
    );

    cmpes_timer #(.CYCLES(FAST_HALF_CYC)) u_fast_tmr (
        .clock   (clock),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .reload  (fast_exp),
        .expired (fast_exp)
    );

    always_comb begin
        slow_tick = slow_exp;
        fast_tick = fast_exp;
    end

    // blink_q counts slow half periods; thirty-two halves make one frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slow_ph_q <= 1'b0;
            fast_ph_q <= 1'b0;
            blink_q   <= 5'h00;
        end else if (clk_en) begin
            if (slow_tick) begin
                slow_ph_q <= !slow_ph_q;
                blink_q   <= 5'(blink_q + 5'h01);
            end
            if (fast_tick) begin
                fast_ph_q <= !fast_ph_q;
            end
        end
    end

    // solenoid count: lit on even halves below twice the count, then a pause
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_indicator <= cmpes_pkg::CMPES_OFF;
        end else if (clk_en) begin
            case (mode)
                cmpes_pkg::CMPES_M_NOCAN:
                    status_indicator <= fast_ph_q ? cmpes_pkg::CMPES_RED : cmpes_pkg::CMPES_OFF;
                cmpes_pkg::CMPES_M_COMPF:
                    status_indicator <= (blink_q[1:0] == 2'h0) ? cmpes_pkg::CMPES_RED
                                                               : cmpes_pkg::CMPES_OFF;
                cmpes_pkg::CMPES_M_SOLF:
                    status_indicator <= (!blink_q[0] && (blink_q[4:1] < sol_blinks))
                                        ? cmpes_pkg::CMPES_RED : cmpes_pkg::CMPES_OFF;
                cmpes_pkg::CMPES_M_STICKY:
                    status_indicator <= slow_ph_q ? cmpes_pkg::CMPES_ORANGE : cmpes_pkg::CMPES_OFF;
                cmpes_pkg::CMPES_M_IDLE:
                    status_indicator <= slow_ph_q ? cmpes_pkg::CMPES_GREEN : cmpes_pkg::CMPES_OFF;
                cmpes_pkg::CMPES_M_RUN:
                    status_indicator <= fast_ph_q ? cmpes_pkg::CMPES_GREEN : cmpes_pkg::CMPES_OFF;
                default:
                    status_indicator <= cmpes_pkg::CMPES_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, then ack

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            ack_q           <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
        end
    end

    // id resets to zero, software may change it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_id_q <= cmpes_pkg::ID_RST;
        end else if (clk_en && avs_write && ack_q && avs_address == cmpes_pkg::REG_DEVID) begin
            dev_id_q <= avs_writedata[cmpes_pkg::ID_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            avs_readdata <= 32'h0000_0000;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    cmpes_pkg::REG_STATUS: begin
                        avs_readdata[cmpes_pkg::ST_DRIVE]       <= comp_drive;
                        avs_readdata[cmpes_pkg::ST_ENABLED]     <= enabled;
                        avs_readdata[cmpes_pkg::ST_CAN_OK]      <= can_ok_q;
                        avs_readdata[cmpes_pkg::ST_CLOSED_LOOP] <= closed_loop_q;
                        avs_readdata[cmpes_pkg::ST_FULL]        <= !press_not_full;
                        avs_readdata[cmpes_pkg::ST_LOCKOUT]     <= lockout;
                    end
                    cmpes_pkg::REG_FAULT: begin
                        avs_readdata[cmpes_pkg::FL_SHORT_NOW]    <= comp_short;
                        avs_readdata[cmpes_pkg::FL_SHORT_STICKY] <= short_sticky_q;
                        avs_readdata[cmpes_pkg::FL_SOL_NOW +: SN]    <= sol_fault;
                        avs_readdata[cmpes_pkg::FL_SOL_STICKY +: SN] <= sol_sticky_q;
                    end
                    cmpes_pkg::REG_DEVID:
                        avs_readdata[cmpes_pkg::ID_W-1:0] <= dev_id_q;
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_drive_terms;
        (clk_en && comp_drive) |-> $past(enabled && press_not_full && closed_loop_q);
    endproperty
    a_drive_terms: assert property (p_drive_terms) else $error("drive without terms");

    property p_ind_match;
        compressor_indicator == comp_drive;
    endproperty
    a_ind_match: assert property (p_ind_match) else $error("indicator mismatch");

    property p_nocan_red;
        (clk_en && !can_ok_q) |=> (status_indicator != cmpes_pkg::CMPES_GREEN);
    endproperty
    a_nocan_red: assert property (p_nocan_red) else $error("green without can");

    property p_sticky_clear;
        (clk_en && sw_clr && !nvm_load && !comp_short) |=> !short_sticky_q;
    endproperty
    a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not cleared");

    sequence s_short_seen;
        clk_en && comp_short && !nvm_load;
    endsequence
    property p_sticky_set;
        s_short_seen |=> short_sticky_q;
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("sticky not set");

    property p_lock_off;
        (clk_en && lockout) |=> !comp_drive;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("drive during retry");

    property p_open_loop;
        (clk_en && !closed_loop_q) |=> !comp_drive;
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("drive open loop");

    property p_full_off;
        (clk_en && !press_not_full) |=> !comp_drive;
    endproperty
    a_full_off: assert property (p_full_off) else $error("drive at full");

    property p_ack_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
endmodule : cmpes_top
`default_nettype wire

// [verification/cmpes_host_model.sv]
// robot controller model: periodic control frames towards the block
`timescale 1ns/1ns
`default_nettype none
module cmpes_host_model #(
    parameter int unsigned PERIOD = 10
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       active,
    input  wire logic [cmpes_pkg::ID_W-1:0] id,
    input  wire logic                       robot_en,
    input  wire logic                       pneu,
    input  wire logic                       closed_loop,
    input  wire logic                       clr,
    output logic                            ctrl_valid,
    output logic      [cmpes_pkg::ID_W-1:0] ctrl_id,
    output logic                            ctrl_robot_en,
    output logic                            ctrl_pneu_used,
    output logic                            ctrl_closed_loop,
    output logic                            ctrl_clr_sticky,
    output logic                            can_frame_ok
);
    int unsigned cnt;
    logic [9:0]  fld_q;
    assign {ctrl_id, ctrl_robot_en, ctrl_pneu_used, ctrl_closed_loop, ctrl_clr_sticky} = fld_q;
    ////////////////////////////////////////////////////////////////////////
    // addressed frame, pneumatics, loop, clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            ctrl_valid <= 1'b0;
            can_frame_ok <= 1'b0;
            fld_q <= '0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            ctrl_valid <= active && cnt == 0;
            can_frame_ok <= active && cnt == 0;
            // fields scramble outside frames, no stale values
            fld_q <= (active && cnt == 0) ? {id, robot_en, pneu, closed_loop, clr} : ~fld_q;
        end
    end
endmodule // cmpes_host_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the compressor enable and status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock = 0, rst_n = 0, clk_en = 1, active = 0, robot_en = 0, pneu = 0, cl = 1, clr = 0;
    logic ctrl_valid, ctrl_robot_en, ctrl_pneu_used, ctrl_closed_loop, ctrl_clr_sticky;
    logic can_frame_ok, can_bus_err = 0, press_not_full = 0, comp_short = 0;
    logic [5:0] ctrl_id, m_id = 0, dev_id;
    logic [7:0] sol_fault = 0;
    logic [8:0] nvm_sticky = 0, nvm_sticky_wr;
    logic [3:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0, avs_waitrequest, comp_drive, compressor_indicator;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [15:0] rnd = 16'h7B64;
    cmpes_pkg::cmpes_color_t status_indicator;
    int fails = 0, check_count = 0, cyc = 0, g, r, o;
    always #50 clock = ~clock;
    cmpes_host_model u_host (.clock(clock), .rst_n(rst_n), .active(active), .id(m_id),
        .robot_en(robot_en), .pneu(pneu), .closed_loop(cl), .clr(clr),
        .ctrl_valid(ctrl_valid), .ctrl_id(ctrl_id), .ctrl_robot_en(ctrl_robot_en),
        .ctrl_pneu_used(ctrl_pneu_used), .ctrl_closed_loop(ctrl_closed_loop),
        .ctrl_clr_sticky(ctrl_clr_sticky), .can_frame_ok(can_frame_ok));
    cmpes_top #(.RETRY_CYC(50), .CTRL_TMO_CYC(40), .CAN_TMO_CYC(40), .SLOW_HALF_CYC(8),
        .FAST_HALF_CYC(4)) dut (.*);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_drive(input logic en, input logic loop, input logic p);
        return en & loop & p;
    endfunction
    function automatic int exp_blinks(input logic [7:0] f);
        for (int i = 0; i < 8; i++) begin
            if (f[i]) return i + 1;
        end
        return 0;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic watch(input int n);
        g = 0; r = 0; o = 0;
        repeat (n) begin
            @(posedge clock);
            g += (status_indicator === cmpes_pkg::CMPES_GREEN);
            r += (status_indicator === cmpes_pkg::CMPES_RED);
            o += (status_indicator === cmpes_pkg::CMPES_ORANGE);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        bus(0, cmpes_pkg::REG_DEVID, 0);
        chk("devid", 0, q);
        bus(0, cmpes_pkg::REG_STATUS, 0);
        chk("status", 32'h8, q & 32'h9);
        rnd = lfsr(rnd);
        dev_id = rnd[5:0] | 6'h01;
        bus(1, cmpes_pkg::REG_DEVID, {26'h0, dev_id});
        bus(0, 4'h2, 0);
        chk("unmapped", 0, q);
        $display("test reset done");
        m_id <= dev_id ^ 6'h01; active <= 1; robot_en <= 1; pneu <= 1; press_not_full <= 1;
        repeat (30) @(posedge clock);
        chk("foreign id drive", 0, comp_drive);
        m_id <= dev_id;
        repeat (25) @(posedge clock);
        chk("drive", 1, comp_drive);
        watch(20);
        chk("run green", 32'h1, {g > 0 && r == 0 && o == 0});
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            press_not_full <= rnd[0];
            repeat (4) @(posedge clock);
            chk("press drive", exp_drive(1, 1, rnd[0]), comp_drive);
            chk("indicator", comp_drive, compressor_indicator);
        end
        cl <= 0; press_not_full <= 1;
        repeat (25) @(posedge clock);
        chk("loop off drive", 0, comp_drive);
        cl <= 1; robot_en <= 0;
        repeat (25) @(posedge clock);
        chk("disabled drive", 0, comp_drive);
        watch(40);
        chk("idle green", 32'h1, {g > 0 && r == 0 && o == 0});
        // 27 cycles is three slow halves of 9 cycles, so a running blink would show
        clk_en <= 0;
        @(posedge clock) q = status_indicator;
        repeat (27) @(posedge clock);
        chk("frozen", q, status_indicator);
        clk_en <= 1;
        $display("test enable done");
        robot_en <= 1;
        repeat (25) @(posedge clock);
        comp_short <= 1;
        repeat (3) @(posedge clock);
        chk("short drive", 0, comp_drive);
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("short flags", 32'h3, q & 32'h3);
        comp_short <= 0;
        bus(0, cmpes_pkg::REG_STATUS, 0);
        chk("lockout", 1, q[cmpes_pkg::ST_LOCKOUT]);
        chk("locked drive", 0, comp_drive);
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("sticky only", 32'h2, q & 32'h3);
        repeat (60) @(posedge clock);
        chk("retry drive", 1, comp_drive);
        robot_en <= 0;
        repeat (25) @(posedge clock);
        watch(40);
        chk("sticky orange", 32'h1, {o > 0 && g == 0});
        chk("nvm image", 1, nvm_sticky_wr[8]);
        clr <= 1;
        repeat (12) @(posedge clock);
        clr <= 0;
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("cleared", 0, q[cmpes_pkg::FL_SHORT_STICKY]);
        rnd = lfsr(rnd);
        nvm_sticky <= rnd[8:0];
        bus(1, cmpes_pkg::REG_CTRL, 32'h2);
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("loaded", {8'h0, rnd[7:0], 14'h0, rnd[8], 1'b0}, q & 32'hFF0002);
        bus(1, cmpes_pkg::REG_CTRL, 32'h1);
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("reg clear", 0, q & 32'hFF0002);
        rnd = lfsr(rnd);
        sol_fault <= rnd[7:0] | 8'h80;
        repeat (3) @(posedge clock);
        bus(0, cmpes_pkg::REG_FAULT, 0);
        chk("sol now", sol_fault, (q >> 8) & 32'hFF);
        // one whole frame: 32 slow halves of 9 cycles
        watch(288);
        chk("sol red", 9 * exp_blinks(sol_fault), r);
        chk("sol green", 0, g);
        sol_fault <= 0;
        $display("test faults done");
        robot_en <= 1;
        repeat (25) @(posedge clock);
        m_id <= dev_id ^ 6'h01;
        repeat (60) @(posedge clock);
        chk("timeout drive", 0, comp_drive);
        active <= 0;
        repeat (60) @(posedge clock);
        watch(30);
        chk("no can red", 32'h1, {r > 0 && g == 0});
        active <= 1;
        repeat (25) @(posedge clock);
        can_bus_err <= 1;
        repeat (3) @(posedge clock);
        watch(30);
        chk("bus err red", 32'h1, {r > 0 && g == 0});
        $display("test can done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
